// file: bench/spc_host_model.sv
module spc_host_model (
   input logic clk_i,
   input logic pready_i,
   input logic [31:0] prdata_i,
   input logic pslverr_i,
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [7:0] paddr_o,
   output logic [31:0] pwdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
   // Request held until pready is sampled; bounded wait
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e, output logic to);
      int n;
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_i);
      penable_o <= 1'b1;
      for (n = 0; n < 9 && pready_i !== 1'b1; n++) @(posedge clk_i);
      to = pready_i !== 1'b1;
      r = prdata_i;
      e = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      pwdata_o <= ~d;
      @(posedge clk_i);
   endtask
endmodule // spc_host_model

// file: bench/spc_port_config_checker.sv
`include "spc_regs.vh"
module spc_port_config_checker (
   input wire clk_i,
   input wire rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire pready_o,
   input wire [31:0] prdata_o,
   input wire pslverr_o,
   input wire [7:0] therm_lp_o,
   input wire [3:0] accel_setup_o,
   input wire alt_char_en_o
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [12:0] cfg = {alt_char_en_o, accel_setup_o, therm_lp_o};
   wire take = psel_i && penable_i && !pready_o;
   wire cmd = take && pwrite_i && paddr_i == `SPC_ADDR_CMD;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_acc; accel_setup_o inside {[1:8]}; endproperty
   a_acc: assert property (p_acc) else $error("accel code range");
   property p_lp; therm_lp_o inside {[1:100]}; endproperty
   a_lp: assert property (p_lp) else $error("low-pass range");
   property p_hold; !cmd |=> $stable(cfg); endproperty
   a_hold: assert property (p_hold) else $error("config moved");
   property p_lvl; !$stable(cfg) |-> $past(pwdata_i[23:20]) >= 4'h2
      && $past(pwdata_i[17:16]) == 2'b11; endproperty
   a_lvl: assert property (p_lvl) else $error("write level");
   property p_rst; $fell(rst_i) |-> cfg == 13'h0564; endproperty
   a_rst: assert property (p_rst) else $error("reset config");
   property p_rdy; take |=> pready_o ##1 !pready_o; endproperty
   a_rdy: assert property (p_rdy) else $error("ready timing");
   property p_rd; pready_o && !pwrite_i && paddr_i == `SPC_ADDR_CFG
      |-> prdata_o[12:0] == cfg; endproperty
   a_rd: assert property (p_rd) else $error("config readback");
   property p_err; pready_o && pwrite_i && paddr_i >= 8'h08
      |-> pslverr_o; endproperty
   a_err: assert property (p_err) else $error("write not refused");
endmodule // spc_port_config_checker
bind spc_port_config spc_port_config_checker i_chk (.clk_i, .rst_i, .psel_i,
   .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .prdata_o,
   .pslverr_o, .therm_lp_o, .accel_setup_o, .alt_char_en_o);

// file: bench/test_sensor_port_config_resource.sv
`include "spc_regs.vh"
module test_sensor_port_config_resource;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, psel_i, penable_i, pwrite_i, pready_o;
   logic pslverr_o, alt_char_en_o, cv, e, to;
   logic [7:0] paddr_i, therm_lp_o, lp;
   logic [3:0] accel_setup_o, acc;
   logic [31:0] pwdata_i, prdata_o, r, rk, rd;
   int errors = 0, samples_checked = 0, seed = 33761;
   always #4 clk_i = ~clk_i;
   spc_port_config i_dut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
      .paddr_i, .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .therm_lp_o,
      .accel_setup_o, .alt_char_en_o);
   spc_host_model i_host (.clk_i, .pready_i(pready_o), .prdata_i(prdata_o),
      .pslverr_i(pslverr_o), .psel_o(psel_i), .penable_o(penable_i),
      .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
   task stop_test();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(string s, logic [31:0] x, logic [31:0] y);
      samples_checked++;
      if (y !== x) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", s, x, y);
      end
   endtask
   task bus(logic w, logic [7:0] a, logic [31:0] d);
      i_host.xfer(w, a, d, r, e, to);
      if (to) begin
         errors++;
         stop_test();
      end
   endtask
   function logic bad(logic [14:0] o, logic [31:0] d);
      if (o[8]) return d[23:1] != 0;
      return d[23:0] != 0 || d[31:24] == 0 || d[31:24] > (o[0] ? 8 : 100);
   endfunction
   task run(logic i, w, logic [3:0] v, logic [14:0] o, logic [31:0] d);
      logic [15:0] c;
      logic [31:0] x;
      c = 0;
      x = 0;
      if (!i) begin
         if (w) c = 16'h1441;
         else if (o > 5) c = 16'h1340;
         else x = o == 0 ? 32'h4745_494F : o == 4 ? 32'h0000_00B4 :
            o == 5 ? 32'h0000_0014 : o == 1 ? 32'h0000_0004 : {o[0], 1'b0};
      end else if (o != 0 && o != 1 && o != 15'h0100) c = 16'h1440;
      else if (w && v < 2) c = 16'h1041;
      else if (w && bad(o, d)) c = 16'h1442;
      else if (!w) x = o[8] ? cv : o[0] ? {4'h0, acc, 24'h0} : {lp, 24'h0};
      else if (o[8]) cv = d[0];
      else if (o[0]) acc = d[27:24];
      else lp = d[31:24];
      bus(1, `SPC_ADDR_WDATA, d);
      bus(1, `SPC_ADDR_CMD, {8'h0, v, 2'h0, w, i, 1'b0, o});
      chk("cmd err", 0, e);
      bus(0, `SPC_ADDR_STATUS, 0);
      chk("status", {c, c != 0, 1'b1}, {r[31:16], r[1:0]});
      bus(0, `SPC_ADDR_RESP_LO, 0);
      chk("resp", x, r);
      chk("cfg", {cv, acc, lp}, {alt_char_en_o, accel_setup_o, therm_lp_o});
   endtask
   initial begin
      lp = 8'h64;
      acc = 4'h5;
      cv = 0;
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      bus(0, `SPC_ADDR_CFG, 0);
      chk("cfg rst", 13'h0564, r[12:0]);
      bus(1, `SPC_ADDR_CFG, 0);
      chk("ro err", 1, e);
      bus(0, 8'h18, 0);
      chk("unmapped", 1, e);
      for (int n = 0; n < 8; n++) run(0, 0, 0, n, 0);
      run(0, 0, 0, 0, 0);
      bus(0, `SPC_ADDR_RESP_HI, 0);
      chk("name hi", 32'h4D41_4E41, r);
      repeat (300) begin
         rk = $random(seed);
         rd = $random(seed);
         case (rd[1:0])
            0: rd = {4'h0, rd[27:24], 24'h0};
            1: rd = {1'b0, rd[30:24], 24'h0};
            2: rd = {31'h0, rd[8]};
         endcase
         run(rk[4], rk[5], rk[9:6], rk[3] ? rk[24:10] : {rk[2], 6'h0, rk[1:0]},
            rd);
      end
      stop_test();
   end
endmodule // test_sensor_port_config_resource

// file: design/spc_port_config.v
`include "spc_regs.vh"

module spc_port_config (
   input wire clk_i,
   input wire rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg pready_o,
   output reg [31:0] prdata_o,
   output reg pslverr_o,
   output reg [7:0] therm_lp_o,
   output reg [3:0] accel_setup_o,
   output reg alt_char_en_o
);

   // One wait state: request taken in first access cycle, pready next
   wire acc = psel_i & penable_i & ~pready_o;
   wire wr_acc = acc & pwrite_i;

   reg [31:0] cmd_r;
   reg [31:0] wdata_r;
   reg [63:0] resp_r;
   reg done_r;
   reg err_r;
   reg [15:0] code_r;

   reg [63:0] resp_nxt;
   reg err_nxt;
   reg [15:0] code_nxt;
   reg [7:0] lp_nxt;
   reg [3:0] acc_nxt;
   reg conv_nxt;

   wire [14:0] off = pwdata_i[`SPC_CMD_OFF_MSB:0];
   wire ind = pwdata_i[`SPC_CMD_IND_BIT];
   wire wr = pwdata_i[`SPC_CMD_WR_BIT];
   wire [3:0] lvl = pwdata_i[`SPC_CMD_LVL_MSB:`SPC_CMD_LVL_LSB];
   wire [7:0] b0 = wdata_r[31:24];
   wire [7:0] b1 = wdata_r[23:16];
   wire [7:0] b2 = wdata_r[15:8];
   wire [7:0] b3 = wdata_r[7:0];

   // Qualifier by direct offset; offset already range checked
   function [63:0] qual_val;
      input [2:0] sel;
      begin
         case (sel)
            3'd0: qual_val = `SPC_NAME_STR;
            3'd1: qual_val = {32'h0000_0000, `SPC_DATA_SIZE};
            3'd2: qual_val = {60'h0, `SPC_RD_LEVEL};
            3'd3: qual_val = {60'h0, `SPC_WR_LEVEL};
            3'd4: qual_val = {32'h0000_0000, `SPC_TIMEOUT};
            3'd5: qual_val = {32'h0000_0000, `SPC_DATA_TYPE};
            default: qual_val = 64'h0000_0000_0000_0000;
         endcase
      end
   endfunction

   // Offset is one of the three supported indirect targets
   function off_ok;
      input [14:0] o;
      begin
         off_ok = (o == `SPC_OFF_THERM) || (o == `SPC_OFF_ACCEL) ||
                  (o == `SPC_OFF_CONV);
      end
   endfunction

   always @* begin
      resp_nxt = 64'h0000_0000_0000_0000;
      err_nxt = 1'b0;
      code_nxt = 16'h0000;
      lp_nxt = therm_lp_o;
      acc_nxt = accel_setup_o;
      conv_nxt = alt_char_en_o;
      if (!ind) begin
         if (wr) begin
            err_nxt = 1'b1;
            code_nxt = `SPC_ERR_DIR_WR;
         end else if (off > `SPC_DIRECT_MAX) begin
            err_nxt = 1'b1;
            code_nxt = `SPC_ERR_DIR_RD;
         end else begin
            resp_nxt = qual_val(off[2:0]);
         end
      end else if (!off_ok(off)) begin
         err_nxt = 1'b1;
         code_nxt = `SPC_ERR_IND_OFF;
      end else if (!wr) begin
         // Read level is zero, so every level may read
         if (lvl < `SPC_RD_LEVEL) begin
            err_nxt = 1'b1;
            code_nxt = `SPC_ERR_DENIED;
         end else if (off[`SPC_OFF_FUNC_BIT]) begin
            resp_nxt = {56'h0, 7'h0, alt_char_en_o};
         end else if (off[`SPC_OFF_PORT_MSB:0] == 7'd0) begin
            resp_nxt = {32'h0, therm_lp_o, 24'h0};
         end else begin
            resp_nxt = {32'h0, 4'h0, accel_setup_o, 24'h0};
         end
      end else if (lvl < `SPC_WR_LEVEL) begin
         err_nxt = 1'b1;
         code_nxt = `SPC_ERR_DENIED;
      end else if (off[`SPC_OFF_FUNC_BIT]) begin
         // First byte is don't-care for the switch
         if (b1 != 8'h00 || b2 != 8'h00 || b3 > 8'h01) begin
            err_nxt = 1'b1;
            code_nxt = `SPC_ERR_VALUE;
         end else begin
            conv_nxt = b3[0];
         end
      end else if (off[`SPC_OFF_PORT_MSB:0] == 7'd0) begin
         if (b0 == 8'h00 || b0 > `SPC_LP_MAX ||
             wdata_r[23:0] != 24'h00_0000) begin
            err_nxt = 1'b1;
            code_nxt = `SPC_ERR_VALUE;
         end else begin
            lp_nxt = b0;
         end
      end else begin
         if (b0 == 8'h00 || b0 > {4'h0, `SPC_ACC_MAX} ||
             wdata_r[23:0] != 24'h00_0000) begin
            err_nxt = 1'b1;
            code_nxt = `SPC_ERR_VALUE;
         end else begin
            acc_nxt = b0[3:0];
         end
      end
   end

   wire cmd_go = wr_acc && (paddr_i == `SPC_ADDR_CMD);

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_r <= 32'h0000_0000;
         wdata_r <= 32'h0000_0000;
         resp_r <= 64'h0000_0000_0000_0000;
         done_r <= 1'b0;
         err_r <= 1'b0;
         code_r <= 16'h0000;
         therm_lp_o <= `SPC_LP_RST;
         accel_setup_o <= `SPC_ACC_RST;
         alt_char_en_o <= `SPC_CONV_RST;
      end else begin
         if (wr_acc && paddr_i == `SPC_ADDR_WDATA) begin
            wdata_r <= pwdata_i;
         end
         if (cmd_go) begin
            // Settings move only on an error-free write
            cmd_r <= pwdata_i;
            resp_r <= resp_nxt;
            done_r <= 1'b1;
            err_r <= err_nxt;
            code_r <= code_nxt;
            therm_lp_o <= lp_nxt;
            accel_setup_o <= acc_nxt;
            alt_char_en_o <= conv_nxt;
         end
      end
   end

   // Read mux and unmapped-address decode
   reg [31:0] rd_nxt;
   reg bad_nxt;
   always @* begin
      rd_nxt = 32'h0000_0000;
      bad_nxt = 1'b0;
      case (paddr_i)
         `SPC_ADDR_CMD: rd_nxt = cmd_r;
         `SPC_ADDR_WDATA: rd_nxt = wdata_r;
         `SPC_ADDR_RESP_LO: rd_nxt = resp_r[31:0];
         `SPC_ADDR_RESP_HI: rd_nxt = resp_r[63:32];
         `SPC_ADDR_STATUS: rd_nxt = {code_r, 14'h0, err_r, done_r};
         `SPC_ADDR_CFG: rd_nxt = {19'h0, alt_char_en_o, accel_setup_o,
                                  therm_lp_o};
         default: bad_nxt = 1'b1;
      endcase
      // Read-only registers refuse writes with an error
      if (pwrite_i && (paddr_i != `SPC_ADDR_CMD) &&
          (paddr_i != `SPC_ADDR_WDATA)) begin
         bad_nxt = 1'b1;
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= acc;
         pslverr_o <= acc & bad_nxt;
         if (acc && !pwrite_i) begin
            prdata_o <= rd_nxt;
         end else begin
            prdata_o <= 32'h0000_0000;
         end
      end
   end

endmodule // spc_port_config

// file: inc/spc_regs.vh
`ifndef SPC_REGS_VH
`define SPC_REGS_VH

// APB register byte addresses
`define SPC_ADDR_CMD 8'h00
`define SPC_ADDR_WDATA 8'h04
`define SPC_ADDR_RESP_LO 8'h08
`define SPC_ADDR_RESP_HI 8'h0C
`define SPC_ADDR_STATUS 8'h10
`define SPC_ADDR_CFG 8'h14

// Command register fields
`define SPC_CMD_OFF_MSB 14
`define SPC_CMD_IND_BIT 16
`define SPC_CMD_WR_BIT 17
`define SPC_CMD_LVL_LSB 20
`define SPC_CMD_LVL_MSB 23

// Indirect offset layout and direct offset limit
`define SPC_OFF_PORT_MSB 6
`define SPC_OFF_FUNC_BIT 8
`define SPC_OFF_THERM 15'h0000
`define SPC_OFF_ACCEL 15'h0001
`define SPC_OFF_CONV 15'h0100
`define SPC_DIRECT_MAX 15'h0005

// Resource qualifiers
`define SPC_NAME_STR 64'h4D41_4E41_4745_494F
`define SPC_DATA_SIZE 32'h0000_0004
`define SPC_RD_LEVEL 4'h0
`define SPC_WR_LEVEL 4'h2
`define SPC_TIMEOUT 32'h0000_00B4
`define SPC_DATA_TYPE 32'h0000_0014

// Error codes
`define SPC_ERR_DIR_RD 16'h1340
`define SPC_ERR_DIR_WR 16'h1441
`define SPC_ERR_IND_OFF 16'h1440
`define SPC_ERR_DENIED 16'h1041
`define SPC_ERR_VALUE 16'h1442

// Setting ranges and reset values
`define SPC_LP_MAX 8'h64
`define SPC_ACC_MAX 4'h8
`define SPC_LP_RST 8'h64
`define SPC_ACC_RST 4'h5
`define SPC_CONV_RST 1'b0

`endif
